// ### dorc_pkg.sv
// Constants, register map, state codes and carrier types of the converter output register control.
package dorc_pkg;

  localparam int unsigned CODE_W      = 16;
  localparam int unsigned SHIFT_W     = 24;
  localparam int unsigned SHIFT_CNT_W = 5;
  localparam logic [4:0]  SHIFT_FULL  = 5'h18;
  localparam logic [4:0]  SHIFT_LAST  = 5'h17;

  // Register offsets.
  localparam logic [7:0] OFF_UPDATE = 8'h02;
  localparam logic [7:0] OFF_PWR    = 8'h03;
  localparam logic [7:0] OFF_GAIN   = 8'h04;
  localparam logic [7:0] OFF_TRIG   = 8'h05;
  localparam logic [7:0] OFF_CODE   = 8'h08;

  // Field positions.
  localparam int unsigned SYNC_EN_BIT  = 0;
  localparam int unsigned AMP_OFF_BIT  = 0;
  localparam int unsigned REF_OFF_BIT  = 8;
  localparam int unsigned GAIN_DBL_BIT = 0;
  localparam int unsigned REF_HALF_BIT = 8;
  localparam int unsigned LOAD_BIT     = 0;
  localparam int unsigned SPI_OFF_HI   = 23;
  localparam int unsigned SPI_OFF_LO   = 16;

  localparam logic [15:0] SOFT_RESTART_CODE = 16'h1010;

  // Reset values; the variant flag picks zero-scale or midscale power-up.
  localparam logic        MIDSCALE_VARIANT = 1'b0;
  localparam logic [15:0] CODE_RESET       = MIDSCALE_VARIANT ? 16'h8000 : 16'h0000;
  localparam logic        SYNC_EN_RESET    = 1'b0;
  localparam logic        AMP_OFF_RESET    = 1'b0;
  localparam logic        REF_OFF_RESET    = 1'b0;
  localparam logic        GAIN_DBL_RESET   = 1'b1;
  localparam logic        REF_HALF_RESET   = 1'b0;

  // Power-on delay before the interfaces are served.
  localparam longint unsigned CLK_HZ       = 10_000_000;
  localparam longint unsigned POR_DELAY_US = 250;
  localparam longint unsigned POR_CYCLES   = (POR_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned     POR_CNT_W    = 12;
  localparam logic [11:0]     POR_LAST     = 12'(POR_CYCLES - 1);

  // Two-wire addressing; the upper address bits are arbitrary, the low bit is a pin.
  localparam logic [5:0] I2C_ADDR_HI = 6'h24;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;
  localparam logic [3:0] RX_BITS     = 4'h8;
  localparam logic [2:0] TX_LAST_BIT = 3'h7;

  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD  = 2'h1;
  localparam logic [1:0] BYTE_MSB  = 2'h2;
  localparam logic [1:0] BYTE_LSB  = 2'h3;

  // Synchroniser lanes.
  localparam int unsigned SYN_SCL  = 0;
  localparam int unsigned SYN_SDA  = 1;
  localparam int unsigned SYN_FS   = 2;
  localparam int unsigned SYN_TGL  = 3;
  localparam int unsigned SYN_MODE = 4;
  localparam int unsigned SYN_A0   = 5;
  localparam int unsigned SYN_HEAD = 6;
  localparam int unsigned SYN_N    = 7;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001,
    I2C_RX   = 5'b00010,
    I2C_ACKO = 5'b00100,
    I2C_TX   = 5'b01000,
    I2C_ACKI = 5'b10000
  } dorc_i2c_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  offset;
    logic [15:0] data;
  } dorc_wreq_t;

  typedef struct packed {
    logic [15:0] active_code;
    logic        internal_ref_enable;
    logic        ref_buffer_enable;
    logic        amp_enable;
    logic        ground_clamp;
    logic        gain_double;
    logic        ref_halve;
    logic        force_zero;
  } dorc_analog_t;

endpackage

// ### dorc_spi_rx.sv
// Serial peripheral receiver running on the link clock: 24-bit shift and frame capture.
`timescale 1ns/1ns
`default_nettype none
module dorc_spi_rx (
  input  wire logic                        spi_sclk,
  input  wire logic                        reset,
  input  wire logic                        frame_strobe_n,
  input  wire logic                        serial_data_in,
  output var  logic [dorc_pkg::SHIFT_W-1:0] word,
  output var  logic                        word_tgl
);
  import dorc_pkg::*;

  logic [SHIFT_CNT_W-1:0] cnt_r;
  logic [SHIFT_W-1:0]     shift_r;
  wire                    clr;
  wire                    shift_en;

  // The strobe being high clears the shifter, so an early end leaves nothing behind.
  assign clr      = reset | frame_strobe_n;
  assign shift_en = (cnt_r != SHIFT_FULL);

  always_ff @(negedge spi_sclk or posedge clr) begin
    if (clr) begin
      cnt_r   <= '0;
      shift_r <= '0;
    end else if (shift_en) begin
      shift_r <= {shift_r[SHIFT_W-2:0], serial_data_in};
      cnt_r   <= cnt_r + 5'h01;
    end
  end

  // The full word is parked here at the 24th edge and announced by a toggle.
  always_ff @(negedge spi_sclk or posedge reset) begin
    if (reset) begin
      word     <= '0;
      word_tgl <= 1'b0;
    end else if (cnt_r == SHIFT_LAST) begin
      word     <= {shift_r[SHIFT_W-2:0], serial_data_in};
      word_tgl <= ~word_tgl;
    end
  end

endmodule
`default_nettype wire

// ### dorc_top.sv
// Top of the converter output register control: interfaces, register file and output controls.
`timescale 1ns/1ns
`default_nettype none
module dorc_top (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  interface_select,
  input  wire logic                  address_select,
  input  wire logic                  spi_sclk,
  input  wire logic                  frame_strobe_n,
  input  wire logic                  serial_data_in,
  input  wire logic                  scl,
  input  wire logic                  sda_in,
  output var  logic                  sda_out,
  output var  logic                  sda_oe_n,
  input  wire logic                  ref_headroom_low,
  output var  dorc_pkg::dorc_analog_t analog_ctl,
  output var  logic                  device_ready
);
  import dorc_pkg::*;

  // Pin synchronisers.
  logic [SYN_N-1:0]   pin_raw;
  logic [SYN_N-1:0]   sync1_r;
  logic [SYN_N-1:0]   sync2_r;
  logic [SHIFT_W-1:0] spi_word;
  logic               spi_tgl;

  assign pin_raw[SYN_SCL]  = scl;
  assign pin_raw[SYN_SDA]  = sda_in;
  assign pin_raw[SYN_FS]   = frame_strobe_n;
  assign pin_raw[SYN_TGL]  = spi_tgl;
  assign pin_raw[SYN_MODE] = interface_select;
  assign pin_raw[SYN_A0]   = address_select;
  assign pin_raw[SYN_HEAD] = ref_headroom_low;

  genvar gi;
  generate
    for (gi = 0; gi < SYN_N; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else if (ce) begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  dorc_spi_rx u_spi_rx (
    .spi_sclk       (spi_sclk),
    .reset          (reset),
    .frame_strobe_n (frame_strobe_n),
    .serial_data_in (serial_data_in),
    .word           (spi_word),
    .word_tgl       (spi_tgl)
  );

  // Power-on delay and interface strap.
  logic [POR_CNT_W-1:0] por_cnt_r;
  logic                 busy_r;
  logic                 mode_i2c_r;
  logic                 restart;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      por_cnt_r  <= '0;
      busy_r     <= 1'b1;
      mode_i2c_r <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        por_cnt_r <= '0;
        busy_r    <= 1'b1;
      end else if (busy_r && por_cnt_r == POR_LAST) begin
        busy_r     <= 1'b0;
        mode_i2c_r <= sync2_r[SYN_MODE];
      end else if (busy_r) begin
        por_cnt_r <= por_cnt_r + 12'h001;
      end
    end
  end

  assign device_ready = ~busy_r;

  // Serial peripheral frame end, checked one cycle late so the toggle has settled.
  logic fs_d1_r;
  logic fs_d2_r;
  logic tgl_seen_r;
  wire  spi_end;
  wire  spi_full;

  assign spi_end  = fs_d1_r & ~fs_d2_r;
  assign spi_full = sync2_r[SYN_TGL] ^ tgl_seen_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fs_d1_r    <= 1'b0;
      fs_d2_r    <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else if (ce) begin
      fs_d1_r <= sync2_r[SYN_FS];
      fs_d2_r <= fs_d1_r;
      if (spi_end) begin
        tgl_seen_r <= sync2_r[SYN_TGL];
      end
    end
  end

  // Two-wire slave.
  dorc_i2c_state_t st_r, st_nxt;
  logic [3:0]      bit_cnt_r, bit_cnt_nxt;
  logic [7:0]      rx_r, rx_nxt;
  logic [7:0]      tx_r, tx_nxt;
  logic [1:0]      byte_r, byte_nxt;
  logic            rw_r, rw_nxt;
  logic            gcall_r, gcall_nxt;
  logic            nack_r, nack_nxt;
  logic            tx_low_r, tx_low_nxt;
  logic [7:0]      ptr_r, ptr_nxt;
  logic [7:0]      msb_r, msb_nxt;
  logic [7:0]      lsb_r, lsb_nxt;
  logic [2:0]      tx_cnt_r, tx_cnt_nxt;
  logic            scl_d_r;
  logic            sda_d_r;
  logic [15:0]     rd_word;

  wire scl_s     = sync2_r[SYN_SCL];
  wire sda_s     = sync2_r[SYN_SDA];
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire i2c_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire i2c_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire i2c_on    = mode_i2c_r & ~busy_r;
  wire my_addr   = (rx_r[7:1] == {I2C_ADDR_HI, sync2_r[SYN_A0]});
  wire gc_addr   = (rx_r[7:1] == GCALL_ADDR) & ~rx_r[0];
  wire ack_fall  = (st_r == I2C_ACKO) & scl_fall;
  // Updates and resets happen on the falling clock that ends the acknowledge.
  wire i2c_commit = ack_fall & (byte_r == BYTE_LSB) & ~rw_r & ~gcall_r;
  wire i2c_gc_rst = ack_fall & (byte_r == BYTE_CMD) & gcall_r;

  always_comb begin
    st_nxt      = st_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt      = rx_r;
    tx_nxt      = tx_r;
    byte_nxt    = byte_r;
    rw_nxt      = rw_r;
    gcall_nxt   = gcall_r;
    nack_nxt    = nack_r;
    tx_low_nxt  = tx_low_r;
    ptr_nxt     = ptr_r;
    msb_nxt     = msb_r;
    lsb_nxt     = lsb_r;
    tx_cnt_nxt  = tx_cnt_r;
    if (!i2c_on || i2c_stop) begin
      st_nxt = I2C_IDLE;
    end else if (i2c_start) begin
      st_nxt      = I2C_RX;
      bit_cnt_nxt = '0;
      byte_nxt    = BYTE_ADDR;
      gcall_nxt   = 1'b0;
      rw_nxt      = 1'b0;
    end else begin
      unique case (st_r)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (scl_rise && bit_cnt_r != RX_BITS) begin
            rx_nxt      = {rx_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == RX_BITS) begin
            st_nxt = I2C_ACKO;
            unique case (byte_r)
              BYTE_ADDR: begin
                rw_nxt    = rx_r[0];
                gcall_nxt = gc_addr;
                if (!my_addr && !gc_addr) begin
                  st_nxt = I2C_IDLE;
                end
              end
              BYTE_CMD: begin
                ptr_nxt = rx_r;
                if (gcall_r && rx_r != GCALL_RESET) begin
                  st_nxt = I2C_IDLE;
                end
              end
              BYTE_MSB: msb_nxt = rx_r;
              BYTE_LSB: lsb_nxt = rx_r;
            endcase
          end
        end
        I2C_ACKO: begin
          if (scl_fall) begin
            byte_nxt    = (byte_r == BYTE_LSB) ? BYTE_MSB : byte_r + 2'h1;
            bit_cnt_nxt = '0;
            if (gcall_r && byte_r == BYTE_CMD) begin
              st_nxt = I2C_IDLE;
            end else if (rw_r) begin
              st_nxt     = I2C_TX;
              tx_nxt     = rd_word[15:8];
              tx_low_nxt = 1'b0;
              tx_cnt_nxt = '0;
            end else begin
              st_nxt = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          if (scl_fall && tx_cnt_r == TX_LAST_BIT) begin
            st_nxt = I2C_ACKI;
          end else if (scl_fall) begin
            tx_nxt     = {tx_r[6:0], 1'b1};
            tx_cnt_nxt = tx_cnt_r + 3'h1;
          end
        end
        I2C_ACKI: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall && nack_r) begin
            st_nxt = I2C_IDLE;
          end else if (scl_fall) begin
            st_nxt     = I2C_TX;
            tx_nxt     = tx_low_r ? rd_word[15:8] : rd_word[7:0];
            tx_low_nxt = ~tx_low_r;
            tx_cnt_nxt = '0;
          end
        end
        default: st_nxt = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r      <= I2C_IDLE;
      {bit_cnt_r, rx_r, tx_r, byte_r, rw_r, gcall_r} <= '0;
      {nack_r, tx_low_r, ptr_r, msb_r, lsb_r, tx_cnt_r} <= '0;
      scl_d_r   <= 1'b0;
      sda_d_r   <= 1'b0;
    end else if (ce) begin
      st_r      <= st_nxt;
      {bit_cnt_r, rx_r, tx_r, byte_r, rw_r, gcall_r} <=
        {bit_cnt_nxt, rx_nxt, tx_nxt, byte_nxt, rw_nxt, gcall_nxt};
      {nack_r, tx_low_r, ptr_r, msb_r, lsb_r, tx_cnt_r} <=
        {nack_nxt, tx_low_nxt, ptr_nxt, msb_nxt, lsb_nxt, tx_cnt_nxt};
      scl_d_r   <= scl_s;
      sda_d_r   <= sda_s;
    end
  end

  // Open drain: only ever pulls low.
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((st_r == I2C_ACKO) | ((st_r == I2C_TX) & ~tx_r[7]));

  // Write request from whichever interface the strap chose.
  dorc_wreq_t spi_req;
  dorc_wreq_t i2c_req;
  dorc_wreq_t wreq;

  assign spi_req.valid  = ~mode_i2c_r & ~busy_r & spi_end & spi_full;
  assign spi_req.offset = spi_word[SPI_OFF_HI:SPI_OFF_LO];
  assign spi_req.data   = spi_word[CODE_W-1:0];
  assign i2c_req.valid  = i2c_commit;
  assign i2c_req.offset = ptr_r;
  assign i2c_req.data   = {msb_r, lsb_r};
  assign wreq           = mode_i2c_r ? i2c_req : spi_req;

  function automatic logic reg_hit(input dorc_wreq_t req, input logic [7:0] off);
    reg_hit = req.valid && (req.offset == off);
  endfunction

  wire wr_update = reg_hit(wreq, OFF_UPDATE);
  wire wr_pwr    = reg_hit(wreq, OFF_PWR);
  wire wr_gain   = reg_hit(wreq, OFF_GAIN);
  wire wr_trig   = reg_hit(wreq, OFF_TRIG);
  wire wr_code   = reg_hit(wreq, OFF_CODE);
  wire soft_rst  = wr_trig & (wreq.data == SOFT_RESTART_CODE);
  wire trig_load = wr_trig & ~soft_rst & wreq.data[LOAD_BIT];

  assign restart = soft_rst | i2c_gc_rst;

  // Register file.
  logic [CODE_W-1:0] buffer_r;
  logic [CODE_W-1:0] active_r;
  logic              sync_en_r;
  logic              amp_off_r;
  logic              ref_off_r;
  logic              gain_dbl_r;
  logic              ref_half_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_en_r  <= SYNC_EN_RESET;
      amp_off_r  <= AMP_OFF_RESET;
      ref_off_r  <= REF_OFF_RESET;
      gain_dbl_r <= GAIN_DBL_RESET;
      ref_half_r <= REF_HALF_RESET;
    end else if (ce && restart) begin
      sync_en_r  <= SYNC_EN_RESET;
      amp_off_r  <= AMP_OFF_RESET;
      ref_off_r  <= REF_OFF_RESET;
      gain_dbl_r <= GAIN_DBL_RESET;
      ref_half_r <= REF_HALF_RESET;
    end else if (ce) begin
      if (wr_update) sync_en_r <= wreq.data[SYNC_EN_BIT];
      if (wr_pwr) amp_off_r <= wreq.data[AMP_OFF_BIT];
      if (wr_pwr) ref_off_r <= wreq.data[REF_OFF_BIT];
      if (wr_gain) gain_dbl_r <= wreq.data[GAIN_DBL_BIT];
      if (wr_gain) ref_half_r <= wreq.data[REF_HALF_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      buffer_r <= CODE_RESET;
      active_r <= CODE_RESET;
    end else if (ce) begin
      if (restart) begin
        buffer_r <= CODE_RESET;
        active_r <= CODE_RESET;
      end else if (wr_code) begin
        buffer_r <= wreq.data;
        if (!sync_en_r) active_r <= wreq.data;
      end else if (trig_load) begin
        active_r <= buffer_r;
      end
    end
  end

  // Read-back; the trigger register has no storage and reads zero.
  assign rd_word = (ptr_r == OFF_CODE)   ? buffer_r :
                   (ptr_r == OFF_UPDATE) ? (16'(sync_en_r) << SYNC_EN_BIT) :
                   (ptr_r == OFF_PWR)    ? ((16'(amp_off_r) << AMP_OFF_BIT) |
                                            (16'(ref_off_r) << REF_OFF_BIT)) :
                   (ptr_r == OFF_GAIN)   ? ((16'(gain_dbl_r) << GAIN_DBL_BIT) |
                                            (16'(ref_half_r) << REF_HALF_BIT)) :
                   16'h0000;

  // Analog controls. The alarm gates only the outputs, so the codes survive it.
  dorc_analog_t ana_nxt;
  wire          ref_alarm = ~ref_half_r & sync2_r[SYN_HEAD];

  assign ana_nxt.active_code         = active_r;
  assign ana_nxt.internal_ref_enable = ~ref_off_r;
  assign ana_nxt.ref_buffer_enable   = ~ref_alarm;
  assign ana_nxt.amp_enable          = ~amp_off_r;
  assign ana_nxt.ground_clamp        = amp_off_r;
  assign ana_nxt.gain_double         = gain_dbl_r;
  assign ana_nxt.ref_halve           = ref_half_r;
  assign ana_nxt.force_zero          = ref_alarm;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      analog_ctl <= '{CODE_RESET, 1'b1, 1'b1, 1'b1, 1'b0, GAIN_DBL_RESET, REF_HALF_RESET, 1'b0};
    end else if (ce) begin
      analog_ctl <= ana_nxt;
    end
  end

endmodule
`default_nettype wire

// ### dorc_host_model.sv
// Host-side serial peripheral master that writes 24-bit frames.
`timescale 1ns/1ns
`default_nettype none
module dorc_host_model (
  output var logic spi_sclk,
  output var logic frame_strobe_n,
  output var logic serial_data_in
);
  initial begin
    spi_sclk = 1'b1;
    frame_strobe_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Sends the top nbits of word, MSB first; fewer than 24 makes an aborted frame.
  task automatic send(input logic [23:0] word, input int nbits);
    frame_strobe_n = 1'b0;
    #10;
    for (int i = 23; i > 23 - nbits; i--) begin
      serial_data_in = word[i];
      #3 spi_sclk = 1'b0;
      #3 spi_sclk = 1'b1;
    end
    #7 frame_strobe_n = 1'b1;
    // A released data line must not keep showing the last bit.
    serial_data_in = ~serial_data_in;
  endtask
endmodule
`default_nettype wire

// ### dorc_checker_properties.sv
// Concurrent checks on the ports of the converter output register control.
`timescale 1ns/1ns
`default_nettype none
module dorc_checker (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   ce,
  input wire logic                   interface_select,
  input wire logic                   frame_strobe_n,
  input wire logic                   sda_out,
  input wire logic                   sda_oe_n,
  input wire dorc_pkg::dorc_analog_t analog_ctl,
  input wire logic                   device_ready
);
  import dorc_pkg::*;
  localparam int READY_MIN = 2499;
  localparam int READY_MAX = 2501;
  logic [11:0] cnt_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 12'h000;
    end else if (device_ready) begin
      cnt_r <= 12'h000;
    end else if (ce) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  reset_values_a: assert property ($fell(reset) |-> analog_ctl[6:0] == 7'h74
    && analog_ctl.active_code == CODE_RESET && !device_ready) else $error("reset values wrong");
  ready_delay_a: assert property ($rose(device_ready) |->
    cnt_r >= READY_MIN && cnt_r <= READY_MAX) else $error("power-on delay wrong");
  ready_defaults_a: assert property ($rose(device_ready) |->
    analog_ctl.active_code == CODE_RESET) else $error("code left reset value early");
  clamp_amp_a: assert property (analog_ctl.ground_clamp == !analog_ctl.amp_enable)
    else $error("ground clamp does not follow amplifier");
  alarm_buffer_a: assert property (analog_ctl.force_zero |-> !analog_ctl.ref_buffer_enable)
    else $error("alarm left reference buffer on");
  alarm_halve_a: assert property (analog_ctl.force_zero |-> !analog_ctl.ref_halve)
    else $error("alarm raised with halving set");
  code_frame_a: assert property ($changed(analog_ctl.active_code) && device_ready |->
    $past(frame_strobe_n, 1) && $past(frame_strobe_n, 2)) else $error("code changed in frame");
  spi_quiet_a: assert property (!interface_select |-> sda_oe_n && !sda_out)
    else $error("two-wire pin driven in serial mode");
  code_cov: cover property ($changed(analog_ctl.active_code) && device_ready);
  alarm_cov: cover property ($rose(analog_ctl.force_zero));
  clamp_cov: cover property ($rose(analog_ctl.ground_clamp));
  ack_cov: cover property ($fell(sda_oe_n));
endmodule
bind dorc_top dorc_checker u_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .ce(ce),
  .interface_select(interface_select),
  .frame_strobe_n(frame_strobe_n),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .analog_ctl(analog_ctl),
  .device_ready(device_ready)
);
`default_nettype wire

// ### testbench.sv
// Self-checking bench that programs the block through serial frames and two-wire transfers.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dorc_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset = 1'b1;
  logic         ref_headroom_low = 1'b0;
  logic         ce = 1'b1;
  logic         strap = 1'b0;
  logic         scl_drv = 1'b1;
  logic         sda_drv = 1'b1;
  logic [15:0]  rd_val;
  wire logic    spi_sclk;
  wire logic    frame_strobe_n;
  wire logic    serial_data_in;
  wire logic    sda_out;
  wire logic    sda_oe_n;
  wire logic    sda_line;
  wire logic    device_ready;
  dorc_analog_t analog_ctl;
  int           err_total = 0;
  int           n_tests = 0;
  int           n;
  always #50 clk_sys = ~clk_sys;
  // The pulled-up data line sits high unless the host or the device pulls it down.
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  dorc_top DUT (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .interface_select(strap),
    .address_select(1'b0),
    .spi_sclk(spi_sclk),
    .frame_strobe_n(frame_strobe_n),
    .serial_data_in(serial_data_in),
    .scl(scl_drv),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .ref_headroom_low(ref_headroom_low),
    .analog_ctl(analog_ctl),
    .device_ready(device_ready)
  );
  dorc_host_model host (
    .spi_sclk(spi_sclk),
    .frame_strobe_n(frame_strobe_n),
    .serial_data_in(serial_data_in)
  );
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_ctl(input logic [15:0] code, input logic [6:0] flags);
    chk("active_code", code, analog_ctl.active_code);
    chk("control_flags", {9'h000, flags}, {9'h000, analog_ctl[6:0]});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Host keeps silent until the device reports the power-on delay over.
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (device_ready !== 1'b1 && cnt < 3000) begin
      tick(1);
      cnt++;
    end
    if (cnt == 3000) begin
      err_total++;
      $display("ERROR device_ready expected 1 seen %b", device_ready);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    host.send({off, d}, 24);
    tick(8);
  endtask
  // Each call holds both pins for five system clocks, well beyond the synchroniser lag.
  task automatic i2c_pin(input logic c, input logic d);
    @(posedge clk_sys);
    scl_drv <= c;
    sda_drv <= d;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic i2c_bit(input logic b, output logic seen);
    i2c_pin(1'b0, sda_drv);
    i2c_pin(1'b0, b);
    i2c_pin(1'b1, b);
    seen = sda_line;
  endtask
  task automatic i2c_tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], s);
    end
    i2c_bit(1'b1, ack);
  endtask
  task automatic i2c_rx(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, b[i]);
    end
    i2c_bit(nack, s);
  endtask
  task automatic i2c_wr(input logic [7:0] off, input logic [15:0] d);
    logic [3:0] ack;
    logic       s;
    i2c_pin(1'b1, 1'b0);
    i2c_tx({I2C_ADDR_HI, 2'h0}, ack[3]);
    i2c_tx(off, ack[2]);
    i2c_tx(d[15:8], ack[1]);
    i2c_tx(d[7:0], ack[0]);
    i2c_bit(1'b0, s);
    i2c_pin(1'b1, 1'b1);
    chk("write_ack", 16'h0000, {12'h000, ack});
  endtask
  // Pointer write, repeated start, then two bytes read, the last one refused.
  task automatic i2c_rd(input logic [7:0] off, output logic [15:0] d);
    logic [2:0] ack;
    logic       s;
    i2c_pin(1'b1, 1'b0);
    i2c_tx({I2C_ADDR_HI, 2'h0}, ack[2]);
    i2c_tx(off, ack[1]);
    i2c_bit(1'b1, s);
    i2c_pin(1'b1, 1'b0);
    i2c_tx({I2C_ADDR_HI, 2'h1}, ack[0]);
    i2c_rx(1'b0, d[15:8]);
    i2c_rx(1'b1, d[7:0]);
    i2c_bit(1'b0, s);
    i2c_pin(1'b1, 1'b1);
    chk("read_ack", 16'h0000, {13'h0000, ack});
  endtask
  initial begin
    tick(2);
    chk_ctl(CODE_RESET, 7'h74);
    chk("device_ready", 16'h0000, {15'h0000, device_ready});
    @(posedge clk_sys);
    @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    wait_ready(n);
    chk("por_cycles", 16'(POR_CYCLES), 16'(n));
    chk_ctl(CODE_RESET, 7'h74);
    wr(OFF_CODE, 16'h1234);
    chk_ctl(16'h1234, 7'h74);
    host.send({OFF_CODE, 16'hFFFF}, 23);
    tick(8);
    chk_ctl(16'h1234, 7'h74);
    wr(OFF_CODE, 16'hFFFF);
    chk_ctl(16'hFFFF, 7'h74);
    wr(OFF_UPDATE, 16'h0001);
    wr(OFF_CODE, 16'h0001);
    chk_ctl(16'hFFFF, 7'h74);
    wr(OFF_TRIG, 16'h0001);
    chk_ctl(16'h0001, 7'h74);
    wr(OFF_CODE, 16'h00A5);
    wr(OFF_TRIG, 16'h0000);
    chk_ctl(16'h0001, 7'h74);
    wr(OFF_GAIN, 16'h0100);
    chk_ctl(16'h0001, 7'h72);
    @(posedge clk_sys) ref_headroom_low <= 1'b1;
    tick(8);
    chk_ctl(16'h0001, 7'h72);
    wr(OFF_GAIN, 16'h0001);
    chk_ctl(16'h0001, 7'h55);
    @(posedge clk_sys) ref_headroom_low <= 1'b0;
    tick(8);
    chk_ctl(16'h0001, 7'h74);
    wr(OFF_PWR, 16'h0101);
    chk_ctl(16'h0001, 7'h2C);
    wr(OFF_PWR, 16'h0001);
    chk_ctl(16'h0001, 7'h6C);
    wr(OFF_TRIG, SOFT_RESTART_CODE);
    chk("device_ready", 16'h0000, {15'h0000, device_ready});
    chk_ctl(CODE_RESET, 7'h74);
    wait_ready(n);
    wr(OFF_CODE, 16'h4321);
    chk_ctl(16'h4321, 7'h74);
    // Power up again with the two-wire strap; the frozen clock enable must stall the delay.
    @(posedge clk_sys);
    strap <= 1'b1;
    reset <= 1'b1;
    ce    <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (100) @(posedge clk_sys);
    ce <= 1'b1;
    #1;
    wait_ready(n);
    chk("por_cycles_ce", 16'(POR_CYCLES), 16'(n));
    chk_ctl(CODE_RESET, 7'h74);
    wr(OFF_CODE, 16'h1234);
    chk_ctl(CODE_RESET, 7'h74);
    i2c_wr(OFF_UPDATE, 16'h0001);
    i2c_wr(OFF_CODE, 16'hBEEF);
    chk_ctl(CODE_RESET, 7'h74);
    i2c_rd(OFF_CODE, rd_val);
    chk("read_code", 16'hBEEF, rd_val);
    i2c_rd(OFF_GAIN, rd_val);
    chk("read_gain", 16'h0001, rd_val);
    i2c_wr(OFF_TRIG, 16'h0001);
    chk_ctl(16'hBEEF, 7'h74);
    i2c_rd(OFF_TRIG, rd_val);
    chk("read_trigger", 16'h0000, rd_val);
    give_verdict();
  end
endmodule
`default_nettype wire
